//--- verilog/socket_cfg.svh
// Offsets, field positions, reset values and counts for the socket control block.
// Assumes inclusion by bare name from each design file that needs it.
`ifndef SOCKET_CFG_SVH
`define SOCKET_CFG_SVH

`define ADDR_W             8
`define OFF_FORCE          8'h0C
`define OFF_CTRL           8'h10
`define OFF_PWR_STAT       8'h14
`define CTRL_RESET         32'h0000_0400
`define BIT_ZV_ACT         11
`define BIT_STD_ZV         10
`define BIT_ZV_EN          9
`define BIT_STOP_POL       7
`define VCC_HI             6
`define VCC_LO             4
`define VPP_HI             2
`define VPP_LO             0
`define FRC_CAP_HI         13
`define FRC_CAP_LO         10
`define FRC_TEST           14
`define IDLE_CLOCKS        4'h8
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

//--- verilog/socket_pkg.sv
// Types shared by the socket control block and its clock-stop decider.
// Assumes the configuration header supplies all numeric constants.
`default_nettype none

package socket_pkg;

  // Supply voltage request codes; 001, 110 and 111 are reserved.
  typedef enum logic [2:0] {
    VCC_OFF  = 3'h0,
    VCC_5V   = 3'h2,
    VCC_3V3  = 3'h3,
    VCC_XV   = 3'h4,
    VCC_YV   = 3'h5
  } vcc_code_type;

  // Programming voltage request codes; 111 is reserved.
  typedef enum logic [2:0] {
    VPP_OFF  = 3'h0,
    VPP_12V  = 3'h1,
    VPP_5V   = 3'h2,
    VPP_3V3  = 3'h3,
    VPP_XV   = 3'h4,
    VPP_YV   = 3'h5,
    VPP_1V8  = 3'h6
  } vpp_code_type;

  // Card clock-run master state.
  typedef enum logic [0:0] {
    CR_RUN   = 1'b0,
    CR_STOP  = 1'b1
  } clkrun_state_type;

endpackage

`default_nettype wire

//--- verilog/clock_stop_decider.sv
// Card clock-run master decision: counts idle card clocks and asks to stop the card clock.
// Assumes i_card_idle and i_host_stop_req are synchronous to i_ref_clk.
`default_nettype none
`include "socket_cfg.svh"

module clock_stop_decider (
  input  wire logic i_ref_clk,
  input  wire logic i_nrst,
  input  wire logic i_policy,
  input  wire logic i_card_idle,
  input  wire logic i_host_stop_req,
  output logic      o_stop_attempt
);

  socket_pkg::clkrun_state_type state;
  socket_pkg::clkrun_state_type next_state;
  logic [3:0]                   idle_cnt;
  logic [3:0]                   next_idle_cnt;
  wire                          idle_enough;
  wire                          stop_cond;

  // The count saturates so a long idle spell never wraps back to busy.
  assign next_idle_cnt = !i_card_idle ? 4'h0 :
                         (idle_cnt == `IDLE_CLOCKS) ? idle_cnt : idle_cnt + 4'h1;
  assign idle_enough   = (idle_cnt == `IDLE_CLOCKS);
  // Policy clear waits for the host request too; policy set ignores it.
  assign stop_cond     = idle_enough && (i_policy || i_host_stop_req);

  // Any card activity or loss of the stop condition drops back to running.
  always_comb begin
    next_state = state;
    unique case (state)
      socket_pkg::CR_RUN:  if (stop_cond) next_state = socket_pkg::CR_STOP;
      socket_pkg::CR_STOP: if (!stop_cond) next_state = socket_pkg::CR_RUN;
    endcase
  end

  // Counter and state registers.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      idle_cnt <= 4'h0;
      state    <= socket_pkg::CR_RUN;
    end else begin
      idle_cnt <= next_idle_cnt;
      state    <= next_state;
    end
  end

  assign o_stop_attempt = (state == socket_pkg::CR_STOP);

endmodule

`default_nettype wire

//--- verilog/socket_supply_clock_control.sv
// Socket supply and clock control register bank with an AXI4-Lite slave port.
// Assumes all inputs are synchronous to i_ref_clk and the power switch honours o_vcc_apply.
//
// Function
// - Reserved control bits read as zero.
// - Activity flag is OR of both sockets' enables.
// - Standard zoomed model flag reads constant one.
// - Zoomed video enable is read/write, resets zero.
// - Policy clear: idle eight and host request.
// - Policy set: idle eight clocks suffices alone.
// - Programming code field, reset off, 111 reserved.
// - Energize socket only at card-accepted voltages, except 12V and 1.8V programming, which skip the card check.
// - Forced capability disables power; test re-enables.
`default_nettype none
`include "socket_cfg.svh"

module socket_supply_clock_control (
  input  wire logic        i_ref_clk,
  input  wire logic        i_nrst,
  // AXI4-Lite slave.
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  // Socket side.
  input  wire logic        i_other_zv_enable,
  input  wire logic        i_cardbus_present,
  input  wire logic [3:0]  i_card_caps,
  input  wire logic        i_card_idle,
  input  wire logic        i_host_stop_req,
  output logic             o_zoomed_video_enable,
  output logic [2:0]       o_vcc_apply,
  output logic [2:0]       o_vpp_apply,
  output logic             o_stop_attempt
);

  // Control fields and power-control state.
  logic       zoomed_video_enable;
  logic       clock_stop_policy;
  logic [2:0] supply_voltage_request;
  logic [2:0] prog_voltage_request;
  logic       power_ctl_enable;
  logic [3:0] forced_caps;
  logic [2:0] vcc_apply;
  logic [2:0] vpp_apply;

  // Write channel holding registers; address and data may arrive in either order.
  logic        aw_held;
  logic [7:0]  aw_addr;
  logic        w_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        bvalid;
  logic [1:0]  bresp;
  logic        rvalid;
  logic [1:0]  rresp;
  logic [31:0] rdata;

  wire        wr_fire;
  wire        wr_ctrl;
  wire        wr_force;
  wire        wr_known;
  wire        ar_fire;
  wire        rd_known;
  wire        zoomed_activity_flag;
  wire [31:0] ctrl_word;
  wire [31:0] stat_word;
  wire [31:0] rd_word;
  wire        force_any;
  wire        card_interrogate_test;
  wire [3:0]  eff_caps;
  wire [2:0]  next_vcc_apply;
  wire [2:0]  next_vpp_apply;
  wire        vcc_ok;
  wire        vpp_ok;
  wire        aw_is_ctrl;
  wire        aw_is_force;
  wire        aw_is_stat;
  wire        ar_is_ctrl;
  wire        ar_is_force;
  wire        ar_is_stat;
  wire        wr_zv_bit;
  wire        wr_policy_bit;
  wire [2:0]  wr_vcc_code;
  wire [2:0]  wr_vpp_code;
  wire [3:0]  wr_force_caps;
  wire        wr_test_bit;

  // Each channel accepts one beat and then waits until the response is gone.
  assign o_awready = !aw_held && !bvalid;
  assign o_wready  = !w_held && !bvalid;
  assign wr_fire   = aw_held && w_held && !bvalid;
  // Word decode of the held write address and the live read address; byte lanes are ignored.
  assign aw_is_ctrl  = (aw_addr[7:2] == 6'(`OFF_CTRL >> 2));
  assign aw_is_force = (aw_addr[7:2] == 6'(`OFF_FORCE >> 2));
  assign aw_is_stat  = (aw_addr[7:2] == 6'(`OFF_PWR_STAT >> 2));
  assign ar_is_ctrl  = (i_araddr[7:2] == 6'(`OFF_CTRL >> 2));
  assign ar_is_force = (i_araddr[7:2] == 6'(`OFF_FORCE >> 2));
  assign ar_is_stat  = (i_araddr[7:2] == 6'(`OFF_PWR_STAT >> 2));

  assign wr_ctrl   = wr_fire && aw_is_ctrl;
  assign wr_force  = wr_fire && aw_is_force;
  assign wr_known  = wr_ctrl || wr_force || aw_is_stat;

  // Named fields of the held write word keep the register processes short.
  assign wr_zv_bit     = w_data[`BIT_ZV_EN];
  assign wr_policy_bit = w_data[`BIT_STOP_POL];
  assign wr_vcc_code   = w_data[`VCC_HI:`VCC_LO];
  assign wr_vpp_code   = w_data[`VPP_HI:`VPP_LO];
  assign wr_force_caps = w_data[`FRC_CAP_HI:`FRC_CAP_LO];
  assign wr_test_bit   = w_data[`FRC_TEST];

  // Forced caps take effect only when the low two bytes are written; the test bit needs byte 1 alone.
  assign force_any             = wr_force && w_strb[1] && w_strb[0]
                                 && (wr_force_caps != 4'h0);
  assign card_interrogate_test = wr_force && w_strb[1] && wr_test_bit;

  // The other socket's enable joins ours to form the shared activity flag.
  assign zoomed_activity_flag = zoomed_video_enable || i_other_zv_enable;

  // Reserved bits are tied low by the concatenation.
  assign ctrl_word = {20'h0_0000,
                      zoomed_activity_flag,
                      1'b1,
                      zoomed_video_enable,
                      1'b0,
                      clock_stop_policy,
                      supply_voltage_request,
                      1'b0,
                      prog_voltage_request};
  // Status word: switch codes, power-control state, presence and effective caps.
  assign stat_word = {17'h0_0000,
                      vcc_apply,                        // Bits 14 to 12.
                      1'b0,
                      vpp_apply,                        // Bits 10 to 8.
                      power_ctl_enable,
                      forced_caps != 4'h0,
                      i_cardbus_present,
                      1'b0,
                      eff_caps};

  // Read decode; unmapped words answer zero with a slave error.
  assign ar_fire  = i_arvalid && !rvalid;
  assign rd_known = ar_is_ctrl || ar_is_force || ar_is_stat;
  // The force word is write-only, so it falls through to zero here.
  assign rd_word  = ar_is_ctrl ? ctrl_word :
                    ar_is_stat ? stat_word : 32'h0000_0000;
  assign o_arready = !rvalid;

  // Forced flags are ORed onto the sensed caps for the status word until the next interrogation.
  assign eff_caps = i_card_caps | forced_caps;

  // Supply is granted only for a defined code that the sensed card accepts.
  assign vcc_ok = (supply_voltage_request == socket_pkg::VCC_5V  && i_card_caps[0])
               || (supply_voltage_request == socket_pkg::VCC_3V3 && i_card_caps[1])
               || (supply_voltage_request == socket_pkg::VCC_XV  && i_card_caps[2])
               || (supply_voltage_request == socket_pkg::VCC_YV  && i_card_caps[3]);
  assign next_vcc_apply = (power_ctl_enable && i_cardbus_present && vcc_ok)
                          ? supply_voltage_request : 3'h0;

  // Programming voltage follows the same checks, except that 12V and 1.8V need no card flag, and never appears without supply.
  // Reserved codes fall through to off, which is the safe reading of an undefined request.
  assign vpp_ok = (prog_voltage_request == socket_pkg::VPP_12V)
               || (prog_voltage_request == socket_pkg::VPP_1V8)
               || (prog_voltage_request == socket_pkg::VPP_5V  && i_card_caps[0])
               || (prog_voltage_request == socket_pkg::VPP_3V3 && i_card_caps[1])
               || (prog_voltage_request == socket_pkg::VPP_XV  && i_card_caps[2])
               || (prog_voltage_request == socket_pkg::VPP_YV  && i_card_caps[3]);
  assign next_vpp_apply = (next_vcc_apply != 3'h0 && vpp_ok)
                          ? prog_voltage_request : 3'h0;

  // Address and data capture.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (i_awvalid && o_awready) begin
      aw_held <= 1'b1;
      aw_addr <= i_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (i_wvalid && o_wready) begin
      w_held <= 1'b1;
      w_data <= i_wdata;
      w_strb <= i_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  // Write response, one per completed write.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      bvalid <= 1'b0;
      bresp  <= `RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp  <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
    end else if (i_bready) begin
      bvalid <= 1'b0;
    end
  end

  // Read answer registered one cycle after the address is taken.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rvalid <= 1'b0;
      rresp  <= `RESP_OKAY;
      rdata  <= 32'h0000_0000;
    end else if (ar_fire) begin
      rvalid <= 1'b1;
      rresp  <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
      rdata  <= rd_word;
    end else if (i_rready) begin
      rvalid <= 1'b0;
    end
  end

  // Control fields; byte 1 carries the zoomed enable, byte 0 the voltages and policy.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      zoomed_video_enable    <= 1'b0;
      clock_stop_policy      <= 1'b0;
      supply_voltage_request <= 3'h0;
      prog_voltage_request   <= 3'h0;
    end else if (wr_ctrl) begin
      if (w_strb[1]) begin
        zoomed_video_enable <= wr_zv_bit;
      end
      if (w_strb[0]) begin
        clock_stop_policy      <= wr_policy_bit;
        supply_voltage_request <= wr_vcc_code;
        prog_voltage_request   <= wr_vpp_code;
      end
    end
  end

  // Interrogation wins over a force in the same write, since it re-reads the card.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      power_ctl_enable <= 1'b1;
      forced_caps      <= 4'h0;
    end else if (card_interrogate_test) begin
      power_ctl_enable <= 1'b1;
      forced_caps      <= 4'h0;
    end else if (force_any) begin
      power_ctl_enable <= 1'b0;
      forced_caps      <= forced_caps | wr_force_caps;
    end
  end

  // Switch commands are registered so the power switch sees glitch-free codes.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      vcc_apply <= 3'h0;
      vpp_apply <= 3'h0;
    end else begin
      vcc_apply <= next_vcc_apply;
      vpp_apply <= next_vpp_apply;
    end
  end

  clock_stop_decider u_stop (
    .i_ref_clk       (i_ref_clk),
    .i_nrst          (i_nrst),
    .i_policy        (clock_stop_policy),
    .i_card_idle     (i_card_idle),
    .i_host_stop_req (i_host_stop_req),
    .o_stop_attempt  (o_stop_attempt)
  );

  assign o_bvalid              = bvalid;
  assign o_bresp               = bresp;
  assign o_rvalid              = rvalid;
  assign o_rresp               = rresp;
  assign o_rdata               = rdata;
  assign o_zoomed_video_enable = zoomed_video_enable;
  assign o_vcc_apply           = vcc_apply;
  assign o_vpp_apply           = vpp_apply;

endmodule

`default_nettype wire

//--- verif/socket_supply_clock_control_asserts.sv
// Checker for the socket supply and clock control block.
// Assumes it is bound to the block and sees only the block's ports.
`default_nettype none

module socket_supply_clock_control_asserts (
  input wire logic        i_ref_clk,
  input wire logic        i_nrst,
  input wire logic        i_cardbus_present,
  input wire logic [3:0]  i_card_caps,
  input wire logic        i_card_idle,
  input wire logic        i_host_stop_req,
  input wire logic        o_zoomed_video_enable,
  input wire logic [2:0]  o_vcc_apply,
  input wire logic [2:0]  o_vpp_apply,
  input wire logic        o_stop_attempt,
  input wire logic        o_bvalid,
  input wire logic        i_bready,
  input wire logic        o_rvalid,
  input wire logic        i_rready,
  input wire logic [31:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] run;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);

  // Consecutive idle samples; saturates so a long idle spell cannot wrap to zero.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) run <= 4'h0;
    else if (!i_card_idle) run <= 4'h0;
    else if (run != 4'hF) run <= run + 4'h1;
  end

  property p_vcc_off;
    !i_cardbus_present |=> o_vcc_apply == 3'h0;
  endproperty
  a_vcc_off: assert property (p_vcc_off) else $error("supply on with no card");
  property p_vcc_5v;
    o_vcc_apply == socket_pkg::VCC_5V |-> $past(i_card_caps[0] && i_cardbus_present);
  endproperty
  a_vcc_5v: assert property (p_vcc_5v) else $error("5V supply not accepted");
  property p_vcc_3v3;
    o_vcc_apply == socket_pkg::VCC_3V3 |-> $past(i_card_caps[1] && i_cardbus_present);
  endproperty
  a_vcc_3v3: assert property (p_vcc_3v3) else $error("3.3V supply not accepted");
  property p_vcc_code;
    o_vcc_apply inside {3'h0, 3'h2, 3'h3, 3'h4, 3'h5};
  endproperty
  a_vcc_code: assert property (p_vcc_code) else $error("reserved supply code applied");
  property p_vpp_code;
    o_vpp_apply != 3'h7;
  endproperty
  a_vpp_code: assert property (p_vpp_code) else $error("reserved prog code applied");
  property p_stop_min;
    $rose(o_stop_attempt) |-> $past(run) >= 4'h8;
  endproperty
  a_stop_min: assert property (p_stop_min) else $error("stop before eight idle");
  property p_stop_host;
    run >= 4'h8 && i_card_idle && i_host_stop_req |=> o_stop_attempt;
  endproperty
  a_stop_host: assert property (p_stop_host) else $error("stop not attempted");
  property p_stop_drop;
    !i_card_idle |-> ##2 !o_stop_attempt;
  endproperty
  a_stop_drop: assert property (p_stop_drop) else $error("stop held while busy");
  property p_zv_write;
    $changed(o_zoomed_video_enable) |-> $rose(o_bvalid);
  endproperty
  a_zv_write: assert property (p_zv_write) else $error("zoomed enable moved alone");
  property p_bvalid_hold;
    o_bvalid && !i_bready |=> o_bvalid;
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped");
  property p_rvalid_hold;
    o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata);
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold) else $error("read data dropped");
endmodule

bind socket_supply_clock_control socket_supply_clock_control_asserts chk (
  .i_ref_clk, .i_nrst, .i_cardbus_present, .i_card_caps, .i_card_idle, .i_host_stop_req,
  .o_zoomed_video_enable, .o_vcc_apply, .o_vpp_apply, .o_stop_attempt,
  .o_bvalid, .i_bready, .o_rvalid, .i_rready, .o_rdata
);

`default_nettype wire

//--- verif/card_socket_model.sv
// Behavioural CardBus card and power switch on the socket side.
// Assumes the bench commands insertion, sensed acceptance and card activity.
`default_nettype none

module card_socket_model (
  input  wire logic       i_ref_clk,
  input  wire logic       i_insert,
  input  wire logic [3:0] i_caps,
  input  wire logic       i_busy,
  input  wire logic [2:0] i_vcc_apply,
  output logic            o_present,
  output logic [3:0]      o_caps,
  output logic            o_idle,
  output var logic        o_fault
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] caps_q = 4'h0;
  logic       bad;
  logic       fault_q = 1'b0;

  // An empty socket leaves the sense lines on their pull-downs.
  assign o_present = i_insert;
  assign o_caps = i_insert ? i_caps : 4'h0;
  assign o_idle = !i_busy;
  // The switch lags a cycle, so supplies are judged against last cycle's sense.
  assign bad = (i_vcc_apply == 3'h2 && !caps_q[0]) || (i_vcc_apply == 3'h3 && !caps_q[1])
            || (i_vcc_apply == 3'h4 && !caps_q[2]) || (i_vcc_apply == 3'h5 && !caps_q[3]);

  // A supply the card cannot take leaves a sticky fault.
  assign o_fault = fault_q;
  always @(posedge i_ref_clk) begin
    caps_q <= o_caps;
    if (bad) fault_q <= 1'h1;
  end
endmodule

`default_nettype wire

//--- verif/socket_supply_clock_control_tb.sv
// Register-level bench for the socket supply and clock control block.
// Assumes the card model stands on the socket side and the checker is bound.
`default_nettype none

module socket_supply_clock_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'h0, nrst = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic        arvalid = 1'h0, rready = 1'h0, other_zv = 1'h0, insert = 1'h0;
  logic        busy = 1'h1, host_req = 1'h0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [3:0]  wstrb = 4'h0, caps = 4'h0, card_caps;
  logic        awready, wready, bvalid, arready, rvalid, present, idle, zv_en, stop, fault;
  logic [1:0]  bresp, rresp;
  logic [2:0]  vcc, vpp;
  logic [2:0]  vc [7] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h1, 3'h6, 3'h7};
  logic [2:0]  ve [7] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h0, 3'h0, 3'h0};
  int          miscompares = 0, checks = 0;

  always #12.5 clk = ~clk;

  socket_supply_clock_control dut (
    .i_ref_clk(clk), .i_nrst(nrst), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
    .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
    .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_other_zv_enable(other_zv),
    .i_cardbus_present(present), .i_card_caps(card_caps), .i_card_idle(idle),
    .i_host_stop_req(host_req), .o_zoomed_video_enable(zv_en), .o_vcc_apply(vcc),
    .o_vpp_apply(vpp), .o_stop_attempt(stop)
  );

  card_socket_model card (
    .i_ref_clk(clk), .i_insert(insert), .i_caps(caps), .i_busy(busy),
    .i_vcc_apply(vcc), .o_present(present), .o_caps(card_caps), .o_idle(idle),
    .o_fault(fault)
  );

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Each channel is dropped at the edge that takes it; bready is raised with the address and data.
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    bready <= 1'h0;
    chk("bresp", 32'(bresp), 32'(er));
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rready <= 1'h0;
    chk("rdata", rdata, e);
    chk("rresp", 32'(rresp), 32'(er));
  endtask

  task test_done;
    if (miscompares == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // The tests need about two hundred cycles; this bound cuts a hang.
  initial begin
    repeat (6000) @(posedge clk);
    miscompares++;
    test_done();
  end

  // Main sequence; reserved codes are written on purpose to see them refused.
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'h1;
    rd(8'h10, 32'h0000_0400, 2'h0);
    wr(8'h10, 32'hFFFF_F6B6, 4'hF, 2'h0);
    rd(8'h10, 32'h0000_0EB6, 2'h0);
    chk("zv_en", 32'(zv_en), 32'h0000_0001);
    wr(8'h10, 32'h0000_0000, 4'hF, 2'h0);
    @(posedge clk);
    other_zv <= 1'h1;
    rd(8'h10, 32'h0000_0C00, 2'h0);
    rd(8'h40, 32'h0000_0000, 2'h2);
    wr(8'h40, 32'hFFFF_FFFF, 4'hF, 2'h2);
    rd(8'h10, 32'h0000_0C00, 2'h0);
    @(posedge clk);
    insert <= 1'h1;
    caps <= 4'hF;
    for (int i = 0; i < 7; i++) begin
      wr(8'h10, {25'h0, vc[i], 4'h0}, 4'h1, 2'h0);
      tick(2);
      chk("vcc", 32'(vcc), 32'(ve[i]));
    end
    for (int i = 0; i < 8; i++) begin
      wr(8'h10, {25'h0, 3'h2, 1'h0, 3'(i)}, 4'h1, 2'h0);
      tick(2);
      chk("vpp", 32'(vpp), (i == 7) ? 32'h0 : 32'(i));
    end
    @(posedge clk);
    caps <= 4'h1;
    wr(8'h10, 32'h0000_0030, 4'h1, 2'h0);
    tick(2);
    chk("vcc", 32'(vcc), 32'h0000_0000);
    wr(8'h10, 32'h0000_0020, 4'h1, 2'h0);
    tick(2);
    chk("vcc", 32'(vcc), 32'h0000_0002);
    wr(8'h0C, 32'h0000_0400, 4'h3, 2'h0);
    tick(2);
    chk("vcc", 32'(vcc), 32'h0000_0000);
    rd(8'h14, 32'h0000_0061, 2'h0);
    rd(8'h0C, 32'h0000_0000, 2'h0);
    wr(8'h0C, 32'h0000_4000, 4'h2, 2'h0);
    tick(2);
    chk("vcc", 32'(vcc), 32'h0000_0002);
    rd(8'h14, 32'h0000_20A1, 2'h0);
    @(posedge clk);
    insert <= 1'h0;
    tick(2);
    chk("vcc", 32'(vcc), 32'h0000_0000);
    wr(8'h10, 32'h0000_0080, 4'h1, 2'h0);
    @(posedge clk);
    busy <= 1'h0;
    tick(8);
    chk("stop", 32'(stop), 32'h0000_0000);
    tick(1);
    chk("stop", 32'(stop), 32'h0000_0001);
    @(posedge clk);
    busy <= 1'h1;
    tick(1);
    chk("stop", 32'(stop), 32'h0000_0001);
    tick(1);
    chk("stop", 32'(stop), 32'h0000_0000);
    wr(8'h10, 32'h0000_0000, 4'h1, 2'h0);
    @(posedge clk);
    busy <= 1'h0;
    tick(20);
    chk("stop", 32'(stop), 32'h0000_0000);
    @(posedge clk);
    host_req <= 1'h1;
    tick(1);
    chk("stop", 32'(stop), 32'h0000_0001);
    chk("fault", 32'(fault), 32'h0000_0000);
    test_done();
  end
endmodule

`default_nettype wire
